// *** hw/esam_delay.v ***
// set/clear delay filter counting millisecond ticks
`timescale 1ns/10ps
`default_nettype none
module esam_delay #(
    parameter SET_MS = 500,
    parameter CLR_MS = 500,
    parameter CW = 12
) (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire ms_tick,
    input wire raw,
    output reg filt_ff
);
    reg [CW-1:0] cnt_ff; // ticks the raw level has disagreed
    // ******************************************
    // filter process
    // ******************************************
    // first tick may be partial, so the wait spans count to count+1 ms
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_ff <= 1'b0;
            cnt_ff <= {CW{1'b0}};
        end else if (ce) begin
            if (raw == filt_ff) begin
                cnt_ff <= {CW{1'b0}}; // agreement restarts the window
            end else if (ms_tick) begin
                if (cnt_ff >= (raw ? SET_MS[CW-1:0] : CLR_MS[CW-1:0])) begin
                    filt_ff <= raw;
                    cnt_ff <= {CW{1'b0}};
                end else begin
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** hw/esam_regs.vh ***
// constants, timing counts and behaviour overview for the e1 alarm manager
// Overview of operation
// RULE1: urgent on line loss, all selftest, fault, 5v
// RULE2: urgent alarm asserted during power-up
// RULE3: deferred on remote, ais, selftest, converter
// RULE4: service alarm follows urgent or deferred
// RULE5: separate relay outputs for urgent, deferred
// RULE6: cut-off press lights lamp, releases relays
// RULE7: panel indicators stay until fault clears
// RULE8: hold over one second: three-second lamp test
// RULE9: hold over three seconds: show, clear history
// RULE10: history keeps last cleared line alarm per span
// RULE11: sync loss: local alarm and ais at once
// RULE12: urgent after 500-750 ms, retire same
// RULE13: received ais: send ais, deferred later
// RULE14: ais ends: stop at once, retire later
// RULE15: remote bit passes, deferred at once
// RULE16: millisecond timebase and debounced cut-off button
`ifndef ESAM_REGS_VH
`define ESAM_REGS_VH
// ******************************************
// timing figures
// ******************************************
`define ESAM_CLK_MHZ 250
`define ESAM_MS_CYCLES (`ESAM_CLK_MHZ * 1000)
`define ESAM_URG_SET_MS 500
`define ESAM_URG_CLR_MS 500
`define ESAM_DEF_SET_MS 250
`define ESAM_DEF_CLR_MS 250
`define ESAM_HOLD_TEST_MS 1000
`define ESAM_HOLD_HIST_MS 3000
`define ESAM_LAMP_MS 3000
`define ESAM_HIST_SHOW_MS 3000
`define ESAM_POWERUP_MS 750
`define ESAM_DEBOUNCE_MS 20
// history field positions (per span)
`define ESAM_HIST_LOCAL 0
`define ESAM_HIST_AIS 1
`define ESAM_HIST_REM 2
`define ESAM_HIST_W 3
`endif

// *** hw/esam_top.v ***
// alarm supervision for the dual-port e1 echo canceller
`timescale 1ns/10ps
`default_nettype none
`include "esam_regs.vh"
module esam_top #(
    parameter MS_CYCLES = `ESAM_MS_CYCLES,
    parameter CHANNELS = 30
) (
    input wire ref_clk,
    input wire rst_n,
    input wire clk_en,
    // port conditions, index 0 send-in, 1 receive-in, from framers
    input wire [1:0] sig_loss,
    input wire [1:0] frame_loss,
    input wire [1:0] mf_sync_loss,
    input wire [1:0] ber_excess,
    input wire [1:0] ais_rx,
    input wire [1:0] mf_ais_rx,
    input wire [1:0] remote_alarm_bit_three,
    // self-test and health
    input wire [CHANNELS-1:0] selftest_fail,
    input wire module_fault,
    input wire supply_5v_lost,
    input wire converter_fail,
    // front panel button, a pin
    input wire alarm_cutoff_button,
    // outputs
    output reg urgent_relay_ff,
    output reg deferred_relay_ff,
    output reg service_relay_ff,
    output reg [1:0] ais_send_ff,
    output reg [1:0] remote_send_ff,
    output reg [1:0] local_led_ff,
    output reg [1:0] ais_led_ff,
    output reg [1:0] remote_led_ff,
    output reg selftest_led_ff,
    output reg cutoff_led_ff,
    output reg alarm_history_display_ff
);
    // ******************************************
    // reset and pin synchronisers
    // ******************************************
    reg rst_s1_ff;
    reg rst_s2_ff;
    wire srst_n = rst_s2_ff; // released copy used everywhere
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    reg btn_s1_ff; // first stage, read only by second
    reg btn_s2_ff;
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            btn_s1_ff <= 1'b0;
            btn_s2_ff <= 1'b0;
        end else if (clk_en) begin
            btn_s1_ff <= alarm_cutoff_button;
            btn_s2_ff <= btn_s1_ff;
        end
    end
    // ******************************************
    // millisecond timebase
    // ******************************************
    reg [17:0] pre_ff; // cycle prescaler
    reg ms_tick_ff; // one-cycle pulse each millisecond
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            pre_ff <= 18'h0;
            ms_tick_ff <= 1'b0;
        end else if (clk_en) begin
            if (pre_ff >= MS_CYCLES[17:0] - 18'h1) begin
                pre_ff <= 18'h0;
                ms_tick_ff <= 1'b1; // [RULE16]
            end else begin
                pre_ff <= pre_ff + 18'h1;
                ms_tick_ff <= 1'b0;
            end
        end
    end
    // ******************************************
    // button debounce and hold timing
    // ******************************************
    reg btn_ff; // debounced level
    reg [4:0] deb_ff; // ms the pin has disagreed
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            btn_ff <= 1'b0;
            deb_ff <= 5'h0;
        end else if (clk_en) begin
            if (btn_s2_ff == btn_ff) begin
                deb_ff <= 5'h0;
            end else if (ms_tick_ff) begin
                if (deb_ff >= `ESAM_DEBOUNCE_MS) begin
                    btn_ff <= btn_s2_ff; // [RULE16]
                    deb_ff <= 5'h0;
                end else begin
                    deb_ff <= deb_ff + 5'h1;
                end
            end
        end
    end
    // ******************************************
    // cut-off sequencer, one-hot
    // ******************************************
    localparam ST_IDLE = 4'h1; // waiting for a press
    localparam ST_HELD = 4'h2; // button down, timing the hold
    localparam ST_LAMP = 4'h4; // lamp test running
    localparam ST_HIST = 4'h8; // history on the indicators
    reg [3:0] st_ff;
    reg [11:0] hold_ff; // ms held
    reg [11:0] show_ff; // ms into lamp or history display
    reg btn_d_ff; // previous debounced level
    reg aco_ff; // relays silenced
    reg hist_clr_ff; // pulse clears the history store
    wire press = btn_ff & ~btn_d_ff;
    wire any_urg;
    wire any_def;
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            st_ff <= ST_IDLE;
            hold_ff <= 12'h0;
            show_ff <= 12'h0;
            btn_d_ff <= 1'b0;
            aco_ff <= 1'b0;
            hist_clr_ff <= 1'b0;
        end else if (clk_en) begin
            btn_d_ff <= btn_ff;
            hist_clr_ff <= 1'b0;
            if (press) begin
                aco_ff <= 1'b1; // [RULE6]
            end else if (!any_urg && !any_def) begin
                aco_ff <= 1'b0; // re-arm once nothing is alarming
            end
            case (st_ff)
                ST_IDLE: begin
                    hold_ff <= 12'h0;
                    if (press) begin
                        st_ff <= ST_HELD;
                    end
                end
                ST_HELD: begin
                    if (!btn_ff) begin
                        // short press only silences; long release picks a mode
                        show_ff <= 12'h0;
                        if (hold_ff > `ESAM_HOLD_HIST_MS) begin
                            st_ff <= ST_HIST; // [RULE9]
                        end else if (hold_ff > `ESAM_HOLD_TEST_MS) begin
                            st_ff <= ST_LAMP; // [RULE8]
                        end else begin
                            st_ff <= ST_IDLE;
                        end
                    end else if (ms_tick_ff && hold_ff != 12'hfff) begin
                        hold_ff <= hold_ff + 12'h1;
                    end
                end
                ST_LAMP: begin
                    if (ms_tick_ff) begin
                        show_ff <= show_ff + 12'h1;
                    end
                    if (show_ff >= `ESAM_LAMP_MS) begin
                        st_ff <= ST_IDLE; // [RULE8]
                    end
                end
                ST_HIST: begin
                    if (ms_tick_ff) begin
                        show_ff <= show_ff + 12'h1;
                    end
                    if (show_ff >= `ESAM_HIST_SHOW_MS) begin
                        hist_clr_ff <= 1'b1; // [RULE9]
                        st_ff <= ST_IDLE;
                    end
                end
                default: begin
                    st_ff <= ST_IDLE;
                end
            endcase
        end
    end
    // ******************************************
    // line condition grading and delays
    // ******************************************
    wire [1:0] sync_lost = sig_loss | frame_loss | mf_sync_loss | ber_excess;
    wire [1:0] ais_in = ais_rx | mf_ais_rx;
    wire [1:0] urg_filt; // delayed sync-loss per port
    wire [1:0] def_filt; // delayed ais per port
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_port
            esam_delay #(
                .SET_MS(`ESAM_URG_SET_MS),
                .CLR_MS(`ESAM_URG_CLR_MS),
                .CW(12)
            ) u_urg (
                .clk(ref_clk),
                .rst_n(srst_n),
                .ce(clk_en),
                .ms_tick(ms_tick_ff),
                .raw(sync_lost[gi]),
                .filt_ff(urg_filt[gi]) // [RULE12]
            );
            esam_delay #(
                .SET_MS(`ESAM_DEF_SET_MS),
                .CLR_MS(`ESAM_DEF_CLR_MS),
                .CW(12)
            ) u_def (
                .clk(ref_clk),
                .rst_n(srst_n),
                .ce(clk_en),
                .ms_tick(ms_tick_ff),
                .raw(ais_in[gi]),
                .filt_ff(def_filt[gi]) // [RULE13] [RULE14]
            );
        end
    endgenerate
    wire all_st_fail = &selftest_fail;
    wire some_st_fail = |selftest_fail;
    assign any_urg = (|urg_filt) | all_st_fail | module_fault | supply_5v_lost; // [RULE1]
    assign any_def = (|remote_alarm_bit_three) | (|def_filt) | some_st_fail
        | converter_fail; // [RULE3] [RULE15]
    // ******************************************
    // power-up urgent window
    // ******************************************
    reg [9:0] pwr_ff; // ms since reset release
    wire pwr_on = pwr_ff < `ESAM_POWERUP_MS;
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            pwr_ff <= 10'h0;
        end else if (clk_en && ms_tick_ff && pwr_on) begin
            pwr_ff <= pwr_ff + 10'h1; // [RULE2]
        end
    end
    // ******************************************
    // history store, one entry per span
    // ******************************************
    reg [`ESAM_HIST_W-1:0] hist_ff [0:1]; // last cleared alarm per span
    reg [1:0] loc_d_ff;
    reg [1:0] ais_d_ff;
    reg [1:0] rem_d_ff;
    reg st_hist_ff; // remembered self-test failure
    integer k;
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            hist_ff[0] <= 3'h0;
            hist_ff[1] <= 3'h0;
            loc_d_ff <= 2'h0;
            ais_d_ff <= 2'h0;
            rem_d_ff <= 2'h0;
            st_hist_ff <= 1'b0;
        end else if (clk_en) begin
            loc_d_ff <= sync_lost;
            ais_d_ff <= ais_in;
            rem_d_ff <= remote_alarm_bit_three;
            if (some_st_fail) begin
                st_hist_ff <= 1'b1; // new failure wins over a clear
            end else if (hist_clr_ff) begin
                st_hist_ff <= 1'b0;
            end
            for (k = 0; k < 2; k = k + 1) begin
                // a clearing edge overwrites; it also wins over the clear
                if (loc_d_ff[k] & ~sync_lost[k]) begin
                    hist_ff[k] <= 3'h1 << `ESAM_HIST_LOCAL; // [RULE10]
                end else if (ais_d_ff[k] & ~ais_in[k]) begin
                    hist_ff[k] <= 3'h1 << `ESAM_HIST_AIS; // [RULE10]
                end else if (rem_d_ff[k] & ~remote_alarm_bit_three[k]) begin
                    hist_ff[k] <= 3'h1 << `ESAM_HIST_REM; // [RULE10]
                end else if (hist_clr_ff) begin
                    hist_ff[k] <= 3'h0; // [RULE9]
                end
            end
        end
    end
    // ******************************************
    // output registers
    // ******************************************
    wire lamp = (st_ff == ST_LAMP);
    wire show = (st_ff == ST_HIST);
    wire urg = any_urg | pwr_on;
    always @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            urgent_relay_ff <= 1'b1; // alarm shown while starting up
            deferred_relay_ff <= 1'b0;
            service_relay_ff <= 1'b1;
            ais_send_ff <= 2'h0;
            remote_send_ff <= 2'h0;
            local_led_ff <= 2'h0;
            ais_led_ff <= 2'h0;
            remote_led_ff <= 2'h0;
            selftest_led_ff <= 1'b0;
            cutoff_led_ff <= 1'b0;
            alarm_history_display_ff <= 1'b0;
        end else if (clk_en) begin
            // power-up alarm ignores cut-off so it is always seen
            urgent_relay_ff <= pwr_on | (any_urg & ~aco_ff); // [RULE2] [RULE5] [RULE6]
            deferred_relay_ff <= any_def & ~aco_ff; // [RULE5] [RULE6]
            service_relay_ff <= pwr_on | ((urg | any_def) & ~aco_ff); // [RULE4]
            ais_send_ff <= sync_lost | ais_in; // [RULE11] [RULE13] [RULE14]
            remote_send_ff <= remote_alarm_bit_three; // [RULE15]
            cutoff_led_ff <= aco_ff | lamp; // [RULE6]
            alarm_history_display_ff <= show;
            if (lamp) begin
                local_led_ff <= 2'h3; // [RULE8]
                ais_led_ff <= 2'h3;
                remote_led_ff <= 2'h3;
                selftest_led_ff <= 1'b1;
            end else if (show) begin
                local_led_ff <= {hist_ff[1][`ESAM_HIST_LOCAL], hist_ff[0][`ESAM_HIST_LOCAL]};
                ais_led_ff <= {hist_ff[1][`ESAM_HIST_AIS], hist_ff[0][`ESAM_HIST_AIS]};
                remote_led_ff <= {hist_ff[1][`ESAM_HIST_REM], hist_ff[0][`ESAM_HIST_REM]};
                selftest_led_ff <= st_hist_ff; // [RULE9]
            end else begin
                // panel follows the faults, untouched by cut-off
                local_led_ff <= sync_lost; // [RULE7] [RULE11]
                ais_led_ff <= ais_in; // [RULE7]
                remote_led_ff <= remote_alarm_bit_three; // [RULE7]
                selftest_led_ff <= some_st_fail;
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/e1_system_alarm_manager_test.sv ***
// self-checking bench for the e1 alarm manager
`timescale 1ns/10ps
`default_nettype none
module e1_system_alarm_manager_test;
    // ****************************************
    // signals
    // ****************************************
    localparam int MS = 2; // clocks per ms tick, shortened for run time
    localparam int CH = 30;
    localparam logic [8:0] URG_MAP = 9'h0e7; // causes that are urgent
    localparam logic [8:0] DEF_MAP = 9'h11c; // causes that are deferred
    logic ref_clk, rst_n, clk_en, module_fault, supply_5v_lost, converter_fail, alarm_cutoff_button;
    logic [1:0] sig_loss, frame_loss, mf_sync_loss, ber_excess, ais_rx, mf_ais_rx;
    logic [1:0] remote_alarm_bit_three;
    logic [CH-1:0] selftest_fail;
    wire urgent_relay_ff, deferred_relay_ff, service_relay_ff, selftest_led_ff, cutoff_led_ff;
    wire alarm_history_display_ff, urgent_lamp_ff, deferred_lamp_ff;
    wire [1:0] ais_send_ff, remote_send_ff, local_led_ff, ais_led_ff, remote_led_ff;
    int bad_count = 0;
    int tests_run = 0;
    esam_top #(.MS_CYCLES(MS), .CHANNELS(CH)) i_dut (.*);
    esam_panel i_panel (.*);
    // 250 mhz clock
    always #2 ref_clk = ~ref_clk;
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk1(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // whole ticks, then past the edge
    task automatic wait_ms(input int n);
        repeat (n * MS) @(posedge ref_clk);
        #1;
    endtask
    // hold beats the 20 ms debounce
    task automatic press(input int n);
        @(posedge ref_clk);
        alarm_cutoff_button <= 1'b1;
        wait_ms(n);
        @(posedge ref_clk);
        alarm_cutoff_button <= 1'b0;
    endtask
    task automatic drv_cause(input int k, input logic v);
        @(posedge ref_clk);
        module_fault <= v && k == 0;
        supply_5v_lost <= v && k == 1;
        selftest_fail <= (v && k == 2) ? '1 : {{(CH-1){1'b0}}, v && k == 3};
        converter_fail <= v && k == 4;
        sig_loss <= {v && k == 5, 1'b0};
        mf_sync_loss <= {1'b0, v && k == 6};
        ber_excess <= {v && k == 7, 1'b0};
        mf_ais_rx <= {1'b0, v && k == 8};
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_powerup;
        chk1("urgent_relay_ff", 1'b1, urgent_relay_ff);
        chk1("service_relay_ff", 1'b1, service_relay_ff);
        wait_ms(800);
        chk1("urgent_relay_ff", 1'b0, urgent_relay_ff);
        $display("test powerup done");
    endtask
    // each cause alone, then withdrawn
    task automatic t_causes;
        for (int k = 0; k < 9; k++) begin
            drv_cause(k, 1'b1);
            wait_ms(760);
            chk1("urgent_relay_ff", URG_MAP[k], urgent_relay_ff);
            chk1("deferred_relay_ff", DEF_MAP[k], deferred_relay_ff);
            chk1("service_relay_ff", 1'b1, service_relay_ff);
            chk1("urgent_lamp_ff", URG_MAP[k], urgent_lamp_ff);
            chk1("deferred_lamp_ff", DEF_MAP[k], deferred_lamp_ff);
            drv_cause(k, 1'b0);
            wait_ms(760);
            chk1("service_relay_ff", 1'b0, service_relay_ff);
        end
        $display("test causes done");
    endtask
    task automatic t_sync;
        @(posedge ref_clk);
        frame_loss <= 2'b01;
        wait_ms(1);
        chk8("ais_send_ff", 8'h01, {6'h0, ais_send_ff});
        chk8("local_led_ff", 8'h01, {6'h0, local_led_ff});
        wait_ms(400);
        chk1("urgent_relay_ff", 1'b0, urgent_relay_ff);
        wait_ms(360);
        chk1("urgent_relay_ff", 1'b1, urgent_relay_ff);
        @(posedge ref_clk);
        frame_loss <= 2'b00;
        wait_ms(1);
        chk8("ais_send_ff", 8'h00, {6'h0, ais_send_ff});
        chk8("local_led_ff", 8'h00, {6'h0, local_led_ff});
        wait_ms(400);
        chk1("urgent_relay_ff", 1'b1, urgent_relay_ff);
        wait_ms(360);
        chk1("urgent_relay_ff", 1'b0, urgent_relay_ff);
        $display("test sync done");
    endtask
    task automatic t_ais;
        @(posedge ref_clk);
        ais_rx <= 2'b10;
        wait_ms(1);
        chk8("ais_send_ff", 8'h02, {6'h0, ais_send_ff});
        chk8("ais_led_ff", 8'h02, {6'h0, ais_led_ff});
        wait_ms(200);
        chk1("deferred_relay_ff", 1'b0, deferred_relay_ff);
        wait_ms(310);
        chk1("deferred_relay_ff", 1'b1, deferred_relay_ff);
        @(posedge ref_clk);
        ais_rx <= 2'b00;
        wait_ms(1);
        chk8("ais_send_ff", 8'h00, {6'h0, ais_send_ff});
        wait_ms(200);
        chk1("deferred_relay_ff", 1'b1, deferred_relay_ff);
        wait_ms(310);
        chk1("deferred_relay_ff", 1'b0, deferred_relay_ff);
        $display("test ais done");
    endtask
    task automatic t_remote;
        @(posedge ref_clk);
        remote_alarm_bit_three <= 2'b10;
        wait_ms(1);
        chk8("remote_send_ff", 8'h02, {6'h0, remote_send_ff});
        chk8("remote_led_ff", 8'h02, {6'h0, remote_led_ff});
        chk1("deferred_relay_ff", 1'b1, deferred_relay_ff);
        @(posedge ref_clk);
        remote_alarm_bit_three <= 2'b00;
        wait_ms(1);
        chk1("deferred_relay_ff", 1'b0, deferred_relay_ff);
        $display("test remote done");
    endtask
    task automatic t_cutoff;
        @(posedge ref_clk);
        frame_loss <= 2'b01;
        wait_ms(760);
        press(50);
        wait_ms(30);
        chk1("cutoff_led_ff", 1'b1, cutoff_led_ff);
        chk1("urgent_relay_ff", 1'b0, urgent_relay_ff);
        chk1("urgent_lamp_ff", 1'b0, urgent_lamp_ff);
        chk8("local_led_ff", 8'h01, {6'h0, local_led_ff});
        @(posedge ref_clk);
        frame_loss <= 2'b00;
        wait_ms(800);
        chk8("local_led_ff", 8'h00, {6'h0, local_led_ff});
        $display("test cutoff done");
    endtask
    task automatic t_lamp;
        press(1500);
        wait_ms(50);
        chk8("all_leds", 8'hff, {local_led_ff, ais_led_ff, remote_led_ff, selftest_led_ff,
            cutoff_led_ff});
        wait_ms(3100);
        chk8("line_leds", 8'h00, {2'b0, local_led_ff, ais_led_ff, remote_led_ff});
        $display("test lamp done");
    endtask
    // span 0 last cleared a local alarm, span 1 a remote one
    task automatic t_hist;
        press(3500);
        wait_ms(50);
        chk1("alarm_history_display_ff", 1'b1, alarm_history_display_ff);
        chk8("history_leds", 8'h12, {2'b0, local_led_ff, ais_led_ff, remote_led_ff});
        wait_ms(3100);
        chk1("alarm_history_display_ff", 1'b0, alarm_history_display_ff);
        press(3500);
        wait_ms(50);
        chk8("history_leds", 8'h00, {2'b0, local_led_ff, ais_led_ff, remote_led_ff});
        wait_ms(3100);
        $display("test history done");
    endtask
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        {module_fault, supply_5v_lost, converter_fail, alarm_cutoff_button} = 4'h0;
        {sig_loss, frame_loss, mf_sync_loss, ber_excess} = 8'h00;
        {ais_rx, mf_ais_rx, remote_alarm_bit_three} = 6'h00;
        selftest_fail = '0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        t_powerup;
        t_causes;
        t_sync;
        t_ais;
        t_remote;
        t_cutoff;
        t_lamp;
        t_hist;
        end_of_test;
    end
    // the scenarios need about 73300 clocks
    initial begin
        repeat (90000) @(posedge ref_clk);
        bad_count++;
        end_of_test;
    end
endmodule
`default_nettype wire

// *** verification/esam_panel.sv ***
// model of the relay contacts and the external alarm panel
`timescale 1ns/10ps
`default_nettype none
module esam_panel (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic urgent_relay_ff,
    input wire logic deferred_relay_ff,
    output var logic urgent_lamp_ff,
    output var logic deferred_lamp_ff
);
    // ****************************************
    // contacts close one cycle after the coil
    // ****************************************
    // each class is wired to its own lamp, no sharing
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            urgent_lamp_ff <= 1'b0;
            deferred_lamp_ff <= 1'b0;
        end else begin
            urgent_lamp_ff <= urgent_relay_ff;
            deferred_lamp_ff <= deferred_relay_ff;
        end
    end
endmodule
`default_nettype wire

// *** verification/esam_top_monitor.sv ***
// concurrent checks on the ports of the e1 alarm manager
`timescale 1ns/10ps
`default_nettype none
module esam_top_monitor #(
    parameter MS_CYCLES = 250000,
    parameter CHANNELS = 30
) (
    input wire ref_clk,
    input wire rst_n,
    input wire clk_en,
    input wire [1:0] sig_loss,
    input wire [1:0] frame_loss,
    input wire [1:0] mf_sync_loss,
    input wire [1:0] ber_excess,
    input wire [1:0] ais_rx,
    input wire [1:0] mf_ais_rx,
    input wire [1:0] remote_alarm_bit_three,
    input wire [CHANNELS-1:0] selftest_fail,
    input wire module_fault,
    input wire supply_5v_lost,
    input wire converter_fail,
    input wire alarm_cutoff_button,
    input wire urgent_relay_ff,
    input wire deferred_relay_ff,
    input wire service_relay_ff,
    input wire [1:0] ais_send_ff,
    input wire [1:0] remote_send_ff,
    input wire [1:0] local_led_ff,
    input wire [1:0] ais_led_ff,
    input wire [1:0] remote_led_ff,
    input wire selftest_led_ff,
    input wire cutoff_led_ff,
    input wire alarm_history_display_ff
);
    // ****************************************
    // helper counters
    // ****************************************
    localparam int SET_CYC = 499 * MS_CYCLES; // slack below set window
    logic [1:0] rdy_cnt_ff; // edges since reset release, saturates at 3
    logic [31:0] run_ff; // consecutive cycles with a sync-loss cause
    wire rdy = (rdy_cnt_ff == 2'h3); // inner reset released
    wire sync_any = |(sig_loss | frame_loss | mf_sync_loss | ber_excess);
    // counters restart on every reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdy_cnt_ff <= 2'h0;
            run_ff <= 32'h0;
        end else begin
            if (!rdy) rdy_cnt_ff <= rdy_cnt_ff + 2'h1;
            run_ff <= sync_any ? run_ff + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ****************************************
    // assertions
    // ****************************************
    a_powerup_urgent: assert property (rdy_cnt_ff == 2'h2 |-> urgent_relay_ff && service_relay_ff)
        else $error("urgent or service relay low at power-up");
    a_ais_on: assert property (rdy && clk_en && (frame_loss[0] || ais_rx[0]) |=> ais_send_ff[0])
        else $error("ais not sent on port 0");
    a_ais_off: assert property (rdy && clk_en && !(sig_loss[0] || frame_loss[0] || mf_sync_loss[0]
        || ber_excess[0] || ais_rx[0] || mf_ais_rx[0]) |=> !ais_send_ff[0])
        else $error("ais still sent on port 0");
    a_remote_pass: assert property (rdy && clk_en |=> remote_send_ff == $past(remote_alarm_bit_three))
        else $error("remote indication not passed through");
    a_remote_deferred: assert property (rdy && clk_en && (|remote_alarm_bit_three) ##1 !cutoff_led_ff
        |-> deferred_relay_ff)
        else $error("deferred relay not raised by remote bit");
    a_local_led: assert property (rdy && clk_en && frame_loss[0] |=> local_led_ff[0])
        else $error("local indicator off on port 0");
    a_service_idle: assert property (rdy && (!urgent_relay_ff && !deferred_relay_ff) [*3]
        |-> !service_relay_ff)
        else $error("service relay on with no alarm");
    a_fault_urgent: assert property (rdy && (module_fault && !cutoff_led_ff) [*4] |-> urgent_relay_ff)
        else $error("urgent relay off during module fault");
    a_urgent_early: assert property (rdy && $rose(urgent_relay_ff) && !module_fault && !supply_5v_lost
        && !(&selftest_fail) && !$past(cutoff_led_ff) && !$past(cutoff_led_ff, 2)
        |-> run_ff >= SET_CYC)
        else $error("urgent relay raised before sync loss persisted");
endmodule
bind esam_top esam_top_monitor #(.MS_CYCLES(MS_CYCLES), .CHANNELS(CHANNELS)) i_mon (.*);
`default_nettype wire
